// ---- inc/plm_map.vh ----
// Register map, codes and reset values of the PIN manager
`ifndef PLM_MAP_VH
`define PLM_MAP_VH
// ==================== Register byte offsets
`define PLM_A_CMD      8'h00
`define PLM_A_STAT     8'h04
`define PLM_A_STATE    8'h08
`define PLM_A_KEYREF   8'h0c
`define PLM_A_DATA0    8'h10
`define PLM_A_DATA1    8'h14
`define PLM_A_DATA2    8'h18
`define PLM_A_DATA3    8'h1c
`define PLM_A_PIN_LO   8'h20
`define PLM_A_PIN_HI   8'h24
`define PLM_A_PUK_LO   8'h28
`define PLM_A_PUK_HI   8'h2c
// ==================== Command codes (CMD bits 7:0)
`define PLM_OP_DISABLE 8'h01
`define PLM_OP_ENABLE  8'h02
`define PLM_OP_UNBLOCK 8'h03
// ==================== Parameter values
`define PLM_LC_EMPTY   8'h00
`define PLM_LC_PIN     8'h08
`define PLM_LC_UNBLK   8'h10
`define PLM_P1_NONE    8'h00
`define PLM_P1_RSVD    8'h01
`define PLM_KREF_NONE  5'h00
`define PLM_Q_USE      8'h08
`define PLM_Q_NOUSE    8'h00
// ==================== Initial counts and options
`define PLM_PIN_TRIES  2'h3
`define PLM_PUK_TRIES  4'ha
`define PLM_BLK_ENABLE 1'b0
`define PLM_KEYREF_RST 5'h01
// ==================== Status words
`define PLM_SW_OK      16'h9000
`define PLM_SW_RETRY   12'h63c
`define PLM_SW_BLOCKED 16'h6983
`define PLM_SW_REFUSED 16'h6985
`define PLM_SW_BADLEN  16'h6700
`define PLM_SW_BADP1   16'h6a86
`define PLM_SW_NOREF   16'h6a88
`define PLM_SW_BADINS  16'h6d00
`define PLM_SW_RST     16'h0000
`endif

// ---- src/plm_core.v ----
// PIN lifecycle command handler with an APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "plm_map.vh"
module plm_core (
  input  wire        core_clk_i,   // 40 MHz clock
  input  wire        srst_i,       // Session reset, sync, high
  input  wire        fac_init_i,   // Personalise persistent state
  input  wire        psel_i,       // APB select
  input  wire        penable_i,    // APB access phase
  input  wire        pwrite_i,     // APB direction
  input  wire [7:0]  paddr_i,      // APB byte address
  input  wire [31:0] pwdata_i,     // APB write data
  output reg  [31:0] prdata_o,     // APB read data
  output reg         pready_o,     // APB ready
  output reg         pslverr_o,    // APB error, unmapped
  output reg         granted_o,    // PIN access condition met
  output reg         se_reval_o,   // Revalidate environment
  output reg  [7:0]  repl_qual_o,  // Replacement usage qualifier
  output reg  [4:0]  repl_kref_o   // Replacement key reference
);

  // ==================== Persistent state
  // Only fac_init_i resets these; a session reset leaves them,
  // so failure counts carry over from one session to the next.
  reg [1:0]  pin_try;      // Remaining PIN tries
  reg [3:0]  puk_try;      // Remaining unblock key tries
  reg        pin_en;       // PIN comparison required
  reg        pin_blk;      // PIN blocked
  reg        puk_blk;      // Unblock key blocked
  reg [63:0] ref_pin;      // Reference PIN value
  reg [63:0] ref_puk;      // Reference unblock key

  // ==================== Session state
  reg        verified;     // Access level satisfied this session
  reg [4:0]  keyref;       // Key reference of this PIN
  reg [31:0] cmd;          // Latched command word
  reg        go;           // Execute latched command
  reg        done;         // Status word valid
  reg [15:0] sw;           // Last status word
  reg [31:0] dat [0:3];    // Command data bytes 1..16

  // ==================== Command fields
  wire [7:0]  op  = cmd[7:0];     // Command code
  wire [7:0]  p1  = cmd[15:8];    // Parameter 1
  wire [7:0]  p2  = cmd[23:16];   // Parameter 2
  wire [7:0]  lc  = cmd[31:24];   // Data length
  wire [63:0] d_a = {dat[1], dat[0]};  // First eight bytes
  wire [63:0] d_b = {dat[3], dat[2]};  // Second eight bytes

  // ==================== APB strobes
  wire acc  = psel_i & penable_i & pready_o;  // Completing access
  wire wr   = acc & pwrite_i;                 // Write takes effect
  wire amap = (paddr_i[1:0] == 2'h0) &&
              (paddr_i <= `PLM_A_PUK_HI);     // Mapped word

  // ==================== Next values from the command engine
  reg [1:0]  next_pin_try;  // PIN tries after command
  reg [3:0]  next_puk_try;  // Key tries after command
  reg        next_pin_en;   // Enabled after command
  reg        next_pin_blk;  // PIN blocked after command
  reg        next_puk_blk;  // Key blocked after command
  reg [63:0] next_ref_pin;  // PIN value after command
  reg        next_verified; // Access level after command
  reg        next_reval;    // Pulse a revalidation
  reg [7:0]  next_qual;     // Qualifier after command
  reg [4:0]  next_kref;     // Replacement ref after command
  reg [15:0] next_sw;       // Status word
  reg        dec_zero;      // Scratch: PIN count hits zero

  // Decode and execute one latched command
  always @* begin
    next_pin_try  = pin_try;
    next_puk_try  = puk_try;
    next_pin_en   = pin_en;
    next_pin_blk  = pin_blk;
    next_puk_blk  = puk_blk;
    next_ref_pin  = ref_pin;
    next_verified = verified;
    next_reval    = 1'b0;
    next_qual     = repl_qual_o;
    next_kref     = repl_kref_o;
    next_sw       = `PLM_SW_OK;
    dec_zero      = (pin_try <= 2'h1);
    // Only the addressed key reference is served here
    if ((p2[4:0] != keyref) ||
        (p2[4:0] == `PLM_KREF_NONE)) begin
      next_sw = `PLM_SW_NOREF;
    end else begin
      case (op)
        `PLM_OP_DISABLE: begin
          if (lc != `PLM_LC_PIN) begin
            next_sw = `PLM_SW_BADLEN;
          end else if ((p1[6:5] != 2'h0) ||
                       (p1 == `PLM_P1_RSVD) ||
                       (p1[7] && (p1[4:0] ==
                        `PLM_KREF_NONE))) begin
            next_sw = `PLM_SW_BADP1;
          end else if (!pin_en || pin_blk) begin
            next_sw = `PLM_SW_REFUSED;
          end else if (d_a == ref_pin) begin
            next_pin_try = `PLM_PIN_TRIES;
            next_pin_en  = 1'b0;
            next_reval   = 1'b1;
            if (p1[7]) begin
              next_qual = `PLM_Q_USE;
              next_kref = p1[4:0];
            end
          end else begin
            // Wrong PIN: stays enabled, may block
            next_pin_try = pin_try - 2'h1;
            next_sw = {`PLM_SW_RETRY, 2'h0, next_pin_try};
            if (dec_zero) begin
              next_pin_try = 2'h0;
              next_pin_blk = 1'b1;
              next_sw = {`PLM_SW_RETRY, 4'h0};
            end
          end
        end
        `PLM_OP_ENABLE: begin
          if (lc != `PLM_LC_PIN) begin
            next_sw = `PLM_SW_BADLEN;
          end else if (p1 != `PLM_P1_NONE) begin
            next_sw = `PLM_SW_BADP1;
          end else if (pin_en || pin_blk) begin
            next_sw = `PLM_SW_REFUSED;
          end else if (d_a == ref_pin) begin
            next_pin_try = `PLM_PIN_TRIES;
            next_pin_en  = 1'b1;
            next_qual    = `PLM_Q_NOUSE;
            next_reval   = 1'b1;
          end else begin
            // Wrong PIN: stays disabled, also once blocked
            next_pin_try = pin_try - 2'h1;
            next_sw = {`PLM_SW_RETRY, 2'h0, next_pin_try};
            if (dec_zero) begin
              next_pin_try = 2'h0;
              next_pin_blk = 1'b1;
              next_pin_en  = `PLM_BLK_ENABLE;
              next_sw = {`PLM_SW_RETRY, 4'h0};
            end
          end
        end
        `PLM_OP_UNBLOCK: begin
          if (p1 != `PLM_P1_NONE) begin
            next_sw = `PLM_SW_BADP1;
          end else if (lc == `PLM_LC_EMPTY) begin
            // A blocked key has count zero, so 63C0 comes out
            next_sw = {`PLM_SW_RETRY, puk_try};
            if (puk_blk) begin
              next_sw = {`PLM_SW_RETRY, 4'h0};
            end
          end else if (lc != `PLM_LC_UNBLK) begin
            next_sw = `PLM_SW_BADLEN;
          end else if (puk_blk) begin
            next_sw = `PLM_SW_BLOCKED;
          end else if (d_a == ref_puk) begin
            // New PIN is one stored value, taken from the second eight bytes
            next_ref_pin  = d_b;
            next_puk_try  = `PLM_PUK_TRIES;
            next_pin_try  = `PLM_PIN_TRIES;
            next_pin_blk  = 1'b0;
            next_pin_en   = 1'b1;
            next_verified = 1'b1;
          end else begin
            // PIN flags are left alone here
            next_puk_try = puk_try - 4'h1;
            next_sw = {`PLM_SW_RETRY, next_puk_try};
            if (puk_try <= 4'h1) begin
              next_puk_try = 4'h0;
              next_puk_blk = 1'b1;
              next_sw = {`PLM_SW_RETRY, 4'h0};
            end
          end
        end
        default: begin
          next_sw = `PLM_SW_BADINS;         // Unknown command
        end
      endcase
    end
  end

  // ==================== Persistent storage
  // Updated only by an executed command or personalisation
  always @(posedge core_clk_i) begin
    if (fac_init_i) begin
      pin_try <= `PLM_PIN_TRIES;
      puk_try <= `PLM_PUK_TRIES;
      pin_en  <= 1'b1;
      pin_blk <= 1'b0;
      puk_blk <= 1'b0;
    end else if (go) begin
      pin_try <= next_pin_try;
      puk_try <= next_puk_try;
      pin_en  <= next_pin_en;
      pin_blk <= next_pin_blk;
      puk_blk <= next_puk_blk;
    end
  end

  // Reference values; personalised over the bus
  always @(posedge core_clk_i) begin
    if (fac_init_i) begin
      ref_pin <= 64'h0;
      ref_puk <= 64'h0;
    end else if (go) begin
      ref_pin <= next_ref_pin;
    end else if (wr) begin
      case (paddr_i)
        `PLM_A_PIN_LO: ref_pin[31:0]  <= pwdata_i;
        `PLM_A_PIN_HI: ref_pin[63:32] <= pwdata_i;
        `PLM_A_PUK_LO: ref_puk[31:0]  <= pwdata_i;
        `PLM_A_PUK_HI: ref_puk[63:32] <= pwdata_i;
        default: begin
        end
      endcase
    end
  end

  // ==================== Command latch and status
  // A CMD write is executed one cycle later; no queue is kept,
  // so software polls done before issuing the next command.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      cmd  <= 32'h0;
      go   <= 1'b0;
      done <= 1'b0;
      sw   <= `PLM_SW_RST;
    end else begin
      go <= wr && (paddr_i == `PLM_A_CMD);
      if (wr && (paddr_i == `PLM_A_CMD)) begin
        cmd  <= pwdata_i;
        done <= 1'b0;
      end else if (go) begin
        sw   <= next_sw;
        done <= 1'b1;
      end
    end
  end

  // ==================== Session flags and outputs
  // Revalidation is a one-cycle pulse after a successful disable or enable
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      verified    <= 1'b0;
      se_reval_o  <= 1'b0;
      granted_o   <= 1'b0;
      repl_qual_o <= `PLM_Q_NOUSE;
      repl_kref_o <= `PLM_KREF_NONE;
    end else begin
      se_reval_o <= go & next_reval;
      if (go) begin
        verified    <= next_verified;
        repl_qual_o <= next_qual;
        repl_kref_o <= next_kref;
      end
      // Disabled grants even if blocked; enabled needs unblock
      granted_o <= !pin_en ||
                   (verified && !pin_blk);
    end
  end

  // ==================== Data and key reference registers
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      keyref <= `PLM_KEYREF_RST;
      dat[0] <= 32'h0;
      dat[1] <= 32'h0;
      dat[2] <= 32'h0;
      dat[3] <= 32'h0;
    end else if (wr) begin
      case (paddr_i)
        `PLM_A_KEYREF: keyref <= pwdata_i[4:0];
        `PLM_A_DATA0:  dat[0] <= pwdata_i;
        `PLM_A_DATA1:  dat[1] <= pwdata_i;
        `PLM_A_DATA2:  dat[2] <= pwdata_i;
        `PLM_A_DATA3:  dat[3] <= pwdata_i;
        default: begin
        end
      endcase
    end
  end

  // ==================== APB slave
  // One wait state: ready rises in the second access cycle
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~amap;
      prdata_o  <= 32'h0;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        case (paddr_i)
          `PLM_A_CMD:    prdata_o <= cmd;
          `PLM_A_STAT:   prdata_o <= {15'h0, done, sw};
          `PLM_A_STATE:  prdata_o <= {3'h0, repl_kref_o,
                                      repl_qual_o, 4'h0,
                                      granted_o, puk_blk,
                                      pin_blk, pin_en,
                                      puk_try, 2'h0, pin_try};
          `PLM_A_KEYREF: prdata_o <= {27'h0, keyref};
          `PLM_A_DATA0:  prdata_o <= dat[0];
          `PLM_A_DATA1:  prdata_o <= dat[1];
          `PLM_A_DATA2:  prdata_o <= dat[2];
          `PLM_A_DATA3:  prdata_o <= dat[3];
          default:       prdata_o <= 32'h0;  // Keys read as zero
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/plm_term.sv ----
// Terminal-side APB master that carries command traffic to the card
`timescale 1ns/1ps
`default_nettype none
module plm_term (
  input  wire logic        core_clk_i, // Clock
  input  wire logic        pready_i,   // Slave ready
  input  wire logic        pslverr_i,  // Slave error
  input  wire logic [31:0] prdata_i,   // Read data
  output logic             psel_o,     // Select
  output logic             penable_o,  // Access phase
  output logic             pwrite_o,   // Direction
  output logic [7:0]       paddr_o,    // Byte address
  output logic [31:0]      pwdata_o    // Write data
);
  // ==========================================
  // Idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  // One transfer, held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    // Wait for ready; only the bench hang guard ends a lost answer
    do begin
      @(posedge core_clk_i);
    end while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released lines must not keep showing the last value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- tb/plm_core_chk.sv ----
// Port-level checker for the PIN lifecycle handler
`timescale 1ns/1ps
`default_nettype none
`include "plm_map.vh"
module plm_chk (
  input wire logic        core_clk_i,  // Clock
  input wire logic        srst_i,      // Session reset
  input wire logic        fac_init_i,  // Personalise
  input wire logic        psel_i,      // APB select
  input wire logic        penable_i,   // APB access
  input wire logic        pwrite_i,    // APB direction
  input wire logic [7:0]  paddr_i,     // APB address
  input wire logic [31:0] pwdata_i,    // APB write data
  input wire logic [31:0] prdata_o,    // APB read data
  input wire logic        pready_o,    // APB ready
  input wire logic        pslverr_o,   // APB error
  input wire logic        granted_o,   // Access condition
  input wire logic        se_reval_o,  // Revalidate pulse
  input wire logic [7:0]  repl_qual_o, // Usage qualifier
  input wire logic [4:0]  repl_kref_o  // Replacement key
);
  // ==========================================
  // Helper logic
  logic [3:0] quiet;   // Cycles since reset or command, saturating
  logic [7:0] last_op; // Opcode of the latest command write
  wire cmd_wr = psel_i && penable_i && pready_o && pwrite_i &&
                paddr_i == `PLM_A_CMD;
  wire unmapped = paddr_i > `PLM_A_PUK_HI || paddr_i[1:0] != 2'b00;
  // Outputs may only move shortly after a command or a reset
  always @(posedge core_clk_i) begin
    if (srst_i || fac_init_i || cmd_wr)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
    if (cmd_wr)
      last_op <= pwdata_i[7:0];
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ==========================================
  // Assertions
  property p_rdy_lat;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("late ready");
  property p_rdy_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("long ready");
  property p_err_map;
    pready_o |-> pslverr_o == unmapped;
  endproperty
  a_err_map: assert property (p_err_map) else $error("bad error flag");
  property p_se_pulse;
    se_reval_o |=> !se_reval_o;
  endproperty
  a_se_pulse: assert property (p_se_pulse)
    else $error("long revalidate");
  property p_se_cause;
    se_reval_o |-> quiet inside {[4'd1:4'd5]} &&
      last_op inside {`PLM_OP_DISABLE, `PLM_OP_ENABLE};
  endproperty
  a_se_cause: assert property (p_se_cause)
    else $error("stray revalidate");
  property p_qual;
    $changed(repl_qual_o) |-> quiet < 4'd6 &&
      ((repl_qual_o == `PLM_Q_USE) == (last_op == `PLM_OP_DISABLE));
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualifier moved wrongly");
  property p_qual_val;
    repl_qual_o == `PLM_Q_USE || repl_qual_o == `PLM_Q_NOUSE;
  endproperty
  a_qual_val: assert property (p_qual_val)
    else $error("qualifier value");
  property p_grant;
    $changed(granted_o) |-> quiet < 4'd6;
  endproperty
  a_grant: assert property (p_grant)
    else $error("stray access change");
  property p_kref;
    $changed(repl_kref_o) |-> quiet < 4'd6;
  endproperty
  a_kref: assert property (p_kref)
    else $error("stray key reference");
  c_se: cover property (se_reval_o);
  c_err: cover property (pready_o && pslverr_o);
  c_grant: cover property ($rose(granted_o));
endmodule
bind plm_core plm_chk u_plm_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .fac_init_i(fac_init_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .granted_o(granted_o),
  .se_reval_o(se_reval_o), .repl_qual_o(repl_qual_o),
  .repl_kref_o(repl_kref_o));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the PIN lifecycle handler
`timescale 1ns/1ps
`default_nettype none
`include "plm_map.vh"
module tb;
  logic        core_clk_i = 1'b0; // Clock
  logic        srst_i = 1'b1;     // Session reset
  logic        fac_init_i = 1'b0; // Personalise
  logic        psel, penable, pwrite, pready, pslverr, granted, se_reval;
  logic [7:0]  paddr, qual;
  logic [4:0]  kref;
  logic [31:0] pwdata, prdata;
  logic [7:0]  p2 = 8'h01;        // Addressed PIN reference
  int          n_fail = 0, tests_run = 0, cyc = 0, se_cnt = 0;
  localparam logic [63:0] BAD = 64'h1;
  localparam logic [63:0] NPIN = 64'h1122_3344_5566_7788;
  always #12.5 core_clk_i = ~core_clk_i;
  plm_core u_plm_core (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .fac_init_i(fac_init_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .granted_o(granted),
    .se_reval_o(se_reval), .repl_qual_o(qual), .repl_kref_o(kref));
  plm_term u_plm_term (
    .core_clk_i(core_clk_i), .pready_i(pready), .pslverr_i(pslverr),
    .prdata_i(prdata), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  // ==========================================
  // Pulse counter and hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (se_reval === 1'b1)
      se_cnt++;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      end_of_test;
    end
  end
  // ==========================================
  // Compare and access tasks
  task automatic cmp(input logic [31:0] g, x, input string m);
    tests_run++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic chk_pin(input logic [31:0] g, x);
    cmp(g, x, "port");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r,
                    output logic e);
    u_plm_term.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_plm_term.xfer(1'b1, a, d, r, e);
  endtask
  task automatic chk_st(input logic [31:0] x);
    logic [31:0] r;
    logic e;
    rd(`PLM_A_STATE, r, e);
    cmp(r & 32'hfff, x, "state");
  endtask
  // Full command: data words, command word, poll for done, check status
  task automatic cmd(input logic [7:0] op, p1, lc, input logic [63:0] k,
                     input logic [63:0] np, input logic [15:0] x);
    logic [31:0] r;
    logic e;
    wr(`PLM_A_DATA0, k[31:0]);
    wr(`PLM_A_DATA1, k[63:32]);
    wr(`PLM_A_DATA2, np[31:0]);
    wr(`PLM_A_DATA3, np[63:32]);
    wr(`PLM_A_CMD, {lc, p2, p1, op});
    // Poll until done; a lost command ends in the hang guard
    do begin
      rd(`PLM_A_STAT, r, e);
    end while (r[16] !== 1'b1);
    cmp({16'h0, r[15:0]}, {16'h0, x}, "status");
  endtask
  task automatic end_of_test;
    $display("Counts: %0d compared, %0d failed", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    int i;
    logic [31:0] r;
    logic e;
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    fac_init_i <= 1'b1;
    @(posedge core_clk_i);
    fac_init_i <= 1'b0;
    chk_st(32'h1a3);
    rd(8'h30, r, e);
    chk_pin(r, 32'h0);
    chk_pin({31'h0, e}, 32'h1);
    $display("Test done: fresh card");
    cmd(`PLM_OP_ENABLE, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6985);
    p2 = 8'h02;
    cmd(`PLM_OP_DISABLE, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6a88);
    p2 = 8'h01;
    cmd(8'h04, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6d00);
    cmd(`PLM_OP_DISABLE, 8'h01, 8'h08, 64'h0, 64'h0, 16'h6a86);
    cmd(`PLM_OP_DISABLE, 8'h80, 8'h08, 64'h0, 64'h0, 16'h6a86);
    wr(`PLM_A_KEYREF, 32'h0);
    p2 = 8'h00;
    cmd(`PLM_OP_DISABLE, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6a88);
    wr(`PLM_A_KEYREF, 32'h1);
    p2 = 8'h01;
    rd(`PLM_A_KEYREF, r, e);
    chk_pin(r, 32'h1);
    cmd(`PLM_OP_DISABLE, 8'h00, 8'h07, 64'h0, 64'h0, 16'h6700);
    cmd(`PLM_OP_DISABLE, 8'h60, 8'h08, 64'h0, 64'h0, 16'h6a86);
    cmd(`PLM_OP_DISABLE, 8'h00, 8'h08, BAD, 64'h0, 16'h63c2);
    cmd(`PLM_OP_DISABLE, 8'h85, 8'h08, 64'h0, 64'h0, 16'h9000);
    chk_st(32'h8a3);
    chk_pin({24'h0, qual}, 32'h08);
    chk_pin({27'h0, kref}, 32'h05);
    cmd(`PLM_OP_DISABLE, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6985);
    $display("Test done: disable");
    for (i = 0; i < 3; i++)
      cmd(`PLM_OP_ENABLE, 8'h00, 8'h08, BAD, 64'h0, 16'h63c2 - i);
    chk_st(32'haa0);
    chk_pin({31'h0, granted}, 32'h1);
    cmd(`PLM_OP_ENABLE, 8'h00, 8'h08, 64'h0, 64'h0, 16'h6985);
    $display("Test done: blocking");
    cmd(`PLM_OP_UNBLOCK, 8'h00, 8'h00, 64'h0, 64'h0, 16'h63ca);
    cmd(`PLM_OP_UNBLOCK, 8'h00, 8'h08, 64'h0, NPIN, 16'h6700);
    cmd(`PLM_OP_UNBLOCK, 8'h01, 8'h10, 64'h0, NPIN, 16'h6a86);
    cmd(`PLM_OP_UNBLOCK, 8'h00, 8'h10, BAD, NPIN, 16'h63c9);
    chk_st(32'ha90);
    cmd(`PLM_OP_UNBLOCK, 8'h00, 8'h10, 64'h0, NPIN, 16'h9000);
    chk_st(32'h9a3);
    cmd(`PLM_OP_DISABLE, 8'h00, 8'h08, 64'h0, 64'h0, 16'h63c2);
    cmd(`PLM_OP_DISABLE, 8'h00, 8'h08, NPIN, 64'h0, 16'h9000);
    cmd(`PLM_OP_ENABLE, 8'h00, 8'h08, NPIN, 64'h0, 16'h9000);
    chk_pin({24'h0, qual}, 32'h00);
    chk_st(32'h9a3);
    $display("Test done: unblock");
    for (i = 0; i < 10; i++) begin
      if (i == 5) begin
        srst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
      end
      cmd(`PLM_OP_UNBLOCK, 8'h00, 8'h10, BAD, NPIN, 16'h63c9 - i);
    end
    cmd(`PLM_OP_UNBLOCK, 8'h00, 8'h10, 64'h0, NPIN, 16'h6983);
    cmd(`PLM_OP_UNBLOCK, 8'h00, 8'h00, 64'h0, 64'h0, 16'h63c0);
    chk_st(32'h503);
    chk_pin({31'h0, granted}, 32'h0);
    chk_pin(se_cnt, 32'h3);
    $display("Test done: key exhaustion");
    end_of_test;
  end
endmodule
`default_nettype wire
